// ===== ucp_pkg.sv
package ucp_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] BAUD_ADDR   = 12'h004;
    localparam logic [11:0] TXDATA_ADDR = 12'h008;
    localparam logic [11:0] RXDATA_ADDR = 12'h00c;
    localparam logic [11:0] STATUS_ADDR = 12'h010;
    localparam logic [11:0] ID_ADDR     = 12'h014;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int CTRL_FLOW_BIT  = 0;
    localparam int CTRL_ACC_BIT   = 1;
    localparam int CTRL_ROUTE_BIT = 2;
    localparam int CTRL_TXEN_BIT  = 3;
    localparam int CTRL_RXEN_BIT  = 4;
    localparam logic [4:0] CTRL_RESET = 5'h18;

    // Status fields
    localparam int ST_TXBUSY_BIT = 0;
    localparam int ST_RXVALID_BIT = 1;
    localparam int ST_FIFOFULL_BIT = 2;
    localparam int ST_FIFOEMPTY_BIT = 3;
    localparam int ST_FRAMEERR_BIT = 4;
    localparam int ST_OVERRUN_BIT = 5;
    localparam int ST_BAUDERR_BIT = 6;

    // Arbitrary identification value, names no maker
    localparam logic [31:0] ID_VALUE = 32'h0000_5a01;

    // ****************************************************************
    // Timing and widths
    // ****************************************************************
    localparam int CLK_HZ        = 100_000_000;
    localparam int BAUD_MIN_BPS  = 300;
    localparam int BAUD_MAX_BPS  = 4_608_000;
    localparam int ACC_MAX_BPS   = 9600;
    localparam int DIV_W         = 20;
    // Divisor is clock cycles per bit; fastest rate rounds down to 21 cycles
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX_BPS);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN_BPS);
    localparam logic [DIV_W-1:0] DIV_ACC_MIN = DIV_W'((CLK_HZ + ACC_MAX_BPS - 1) / ACC_MAX_BPS);
    localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / 115200);
    localparam int DATA_W        = 8;
    localparam int FIFO_DEPTH    = 8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [1:0] {UCP_TX_IDLE, UCP_TX_START, UCP_TX_DATA, UCP_TX_STOP} ucp_tx_e;
    typedef enum logic [1:0] {UCP_RX_IDLE, UCP_RX_START, UCP_RX_DATA, UCP_RX_STOP} ucp_rx_e;
endpackage

// ===== ucp_fifo.sv
`timescale 1ns/1ps
module ucp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // ucp_fifo

// ===== ucp_uart.sv
// Overview of operation
// - Full-duplex port with separate transmit output and receive input.
// - Firmware divisor sets baud rate between 300 bps and 4608 Kbps.
// - With flow control on, a character starts only while clear-to-send is high.
// - With flow control on, request-to-send is high while receive space exists.
// - Accessory mode drives transmit onto D-; it receives from D+ (ANDed with the parallel port input) only when routed to the parallel port.
// - Accessory mode disables the USB transceiver; D+/D- pass serial traffic.
// - Accessory signals route to the parallel programmable port or two GPIO pins.
// - Accessory mode rate must not exceed 9600 bps; a faster divisor already applied stays in use, with the error flag set.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ucp_uart
    import ucp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Dedicated serial pins
    output logic             txd,
    input  wire logic        rxd,
    input  wire logic        cts,
    output logic             rts,
    // USB lines in accessory mode
    output logic             usb_xcvr_en,
    output logic             usb_dm_out,
    output logic             usb_dm_oe,
    input  wire logic        usb_dp_in,
    // Accessory routing: parallel programmable port
    output logic             parallel_programmable_port_tx,
    input  wire logic        parallel_programmable_port_rx,
    // Accessory routing: general-purpose pins (GPIO 48 transmit, GPIO 49 receive)
    output logic             gpio48_out,
    output logic             gpio48_oe,
    input  wire logic        gpio49_in
);
    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [4:0]       ctrl_reg;
    logic [4:0]       ctrl_pend_reg;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_pend_reg;
    logic             baud_err_reg;
    logic             frame_err_reg;
    logic             overrun_reg;
    logic [DATA_W-1:0] rx_hold_reg;
    logic             rx_valid_reg;

    logic             wr_en;
    logic             rd_en;
    logic             idle;
    logic             fifo_in_valid;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic             fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;

    function automatic logic div_ok(input logic [DIV_W-1:0] d, input logic acc);
        div_ok = (d >= DIV_MIN) && (d <= DIV_MAX) && (!acc || d >= DIV_ACC_MIN);
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // ****************************************************************
    // APB: one wait state, one access phase per transfer
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            // pready is raised one cycle into the access phase
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && penable && !pready) begin
                unique case (paddr)
                    CTRL_ADDR:   prdata <= {27'h0, ctrl_pend_reg};
                    BAUD_ADDR:   prdata <= {12'h0, div_pend_reg};
                    TXDATA_ADDR: prdata <= '0;
                    RXDATA_ADDR: prdata <= {23'h0, rx_valid_reg, rx_hold_reg};
                    STATUS_ADDR: prdata <= {25'h0, baud_err_reg, overrun_reg, frame_err_reg,
                                            !fifo_out_valid, !fifo_in_ready, rx_valid_reg, !idle};
                    ID_ADDR:     prdata <= ID_VALUE;
                    default:     pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Pending configuration; applied only when both directions idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_pend_reg <= CTRL_RESET;
            div_pend_reg  <= DIV_RESET;
            ctrl_reg      <= CTRL_RESET;
            div_reg       <= DIV_RESET;
            baud_err_reg  <= 1'b0;
        end else begin
            if (wr_en && pready && paddr == CTRL_ADDR) begin
                ctrl_pend_reg <= pwdata[4:0];
            end
            if (wr_en && pready && paddr == BAUD_ADDR) begin
                div_pend_reg <= pwdata[DIV_W-1:0];
            end
            if (idle) begin
                ctrl_reg <= ctrl_pend_reg;
                // Out-of-range divisors are refused and flagged, keeping the old rate
                if (div_ok(div_pend_reg, ctrl_pend_reg[CTRL_ACC_BIT])) begin
                    div_reg      <= div_pend_reg;
                    baud_err_reg <= 1'b0;
                end else begin
                    baud_err_reg <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Transmit path: FIFO then shifter
    // ****************************************************************
    assign fifo_in_valid = wr_en && pready && paddr == TXDATA_ADDR;

    ucp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[DATA_W-1:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    ucp_tx_e           tx_state_reg;
    logic [DIV_W-1:0]  tx_cnt_reg;
    logic [3:0]        tx_bit_reg;
    logic [DATA_W-1:0] tx_shift_reg;
    logic              tx_line_reg;
    logic              tx_tick;
    logic              rx_line;
    logic              cts_ok;

    assign tx_tick = (tx_cnt_reg == div_reg - 1'b1);
    assign cts_ok  = !ctrl_reg[CTRL_FLOW_BIT] || cts;
    assign fifo_out_ready = (tx_state_reg == UCP_TX_IDLE) && ctrl_reg[CTRL_TXEN_BIT] && cts_ok;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_reg <= UCP_TX_IDLE;
            tx_cnt_reg   <= '0;
            tx_bit_reg   <= '0;
            tx_shift_reg <= '0;
            tx_line_reg  <= 1'b1;
        end else begin
            tx_cnt_reg <= (tx_state_reg == UCP_TX_IDLE || tx_tick) ? '0 : tx_cnt_reg + 1'b1;
            unique case (tx_state_reg)
                UCP_TX_IDLE: begin
                    tx_line_reg <= 1'b1;
                    if (fifo_out_valid && fifo_out_ready) begin
                        tx_shift_reg <= fifo_out_data;
                        tx_line_reg  <= 1'b0;
                        tx_state_reg <= UCP_TX_START;
                    end
                end
                UCP_TX_START: begin
                    if (tx_tick) begin
                        tx_line_reg  <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                        tx_bit_reg   <= '0;
                        tx_state_reg <= UCP_TX_DATA;
                    end
                end
                UCP_TX_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_reg == LAST_BIT) begin
                            tx_line_reg  <= 1'b1;
                            tx_state_reg <= UCP_TX_STOP;
                        end else begin
                            tx_line_reg  <= tx_shift_reg[0];
                            tx_shift_reg <= tx_shift_reg >> 1;
                            tx_bit_reg   <= tx_bit_reg + 1'b1;
                        end
                    end
                end
                UCP_TX_STOP: begin
                    if (tx_tick) begin
                        tx_state_reg <= UCP_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Receive path
    // ****************************************************************
    ucp_rx_e           rx_state_reg;
    logic [DIV_W-1:0]  rx_cnt_reg;
    logic [3:0]        rx_bit_reg;
    logic [DATA_W-1:0] rx_shift_reg;
    logic              rx_tick;
    logic              rx_half;

    // Receive source follows the accessory routing
    assign rx_line = !ctrl_reg[CTRL_ACC_BIT] ? rxd :
                     ctrl_reg[CTRL_ROUTE_BIT] ? gpio49_in :
                     (usb_dp_in & parallel_programmable_port_rx);
    assign rx_tick = (rx_cnt_reg == div_reg - 1'b1);
    assign rx_half = (rx_cnt_reg == (div_reg >> 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_reg  <= UCP_RX_IDLE;
            rx_cnt_reg    <= '0;
            rx_bit_reg    <= '0;
            rx_shift_reg  <= '0;
            rx_hold_reg   <= '0;
            rx_valid_reg  <= 1'b0;
            frame_err_reg <= 1'b0;
            overrun_reg   <= 1'b0;
        end else begin
            rx_cnt_reg <= (rx_state_reg == UCP_RX_IDLE || rx_tick) ? '0 : rx_cnt_reg + 1'b1;
            // Reading the data register releases the holding word; a new word wins the same cycle
            if (rd_en && pready && paddr == RXDATA_ADDR) begin
                rx_valid_reg <= 1'b0;
            end
            if (rd_en && pready && paddr == STATUS_ADDR) begin
                frame_err_reg <= 1'b0;
                overrun_reg   <= 1'b0;
            end
            unique case (rx_state_reg)
                UCP_RX_IDLE: begin
                    if (!rx_line && ctrl_reg[CTRL_RXEN_BIT]) begin
                        rx_state_reg <= UCP_RX_START;
                    end
                end
                UCP_RX_START: begin
                    // Start bit checked at mid-bit to reject glitches
                    if (rx_half) begin
                        rx_state_reg <= rx_line ? UCP_RX_IDLE : UCP_RX_DATA;
                        rx_bit_reg   <= '0;
                    end
                end
                UCP_RX_DATA: begin
                    if (rx_half) begin
                        rx_shift_reg <= {rx_line, rx_shift_reg[DATA_W-1:1]};
                        if (rx_bit_reg == LAST_BIT) begin
                            rx_state_reg <= UCP_RX_STOP;
                        end
                        rx_bit_reg <= rx_bit_reg + 1'b1;
                    end
                end
                UCP_RX_STOP: begin
                    if (rx_half) begin
                        rx_state_reg <= UCP_RX_IDLE;
                        if (!rx_line) begin
                            frame_err_reg <= 1'b1;
                        end else if (rx_valid_reg && !(rd_en && pready && paddr == RXDATA_ADDR)) begin
                            overrun_reg <= 1'b1;
                        end else begin
                            rx_hold_reg  <= rx_shift_reg;
                            rx_valid_reg <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign idle = (tx_state_reg == UCP_TX_IDLE) && (rx_state_reg == UCP_RX_IDLE) && !fifo_out_valid;

    // ****************************************************************
    // Pin multiplexing, all outputs registered
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txd                           <= 1'b1;
            rts                           <= 1'b0;
            usb_xcvr_en                   <= 1'b1;
            usb_dm_out                    <= 1'b1;
            usb_dm_oe                     <= 1'b0;
            parallel_programmable_port_tx <= 1'b1;
            gpio48_out                    <= 1'b1;
            gpio48_oe                     <= 1'b0;
        end else begin
            // Space exists while the holding word is free
            rts <= !ctrl_reg[CTRL_FLOW_BIT] || !rx_valid_reg;
            txd <= ctrl_reg[CTRL_ACC_BIT] ? 1'b1 : tx_line_reg;
            usb_xcvr_en <= !ctrl_reg[CTRL_ACC_BIT];
            usb_dm_out  <= tx_line_reg;
            usb_dm_oe   <= ctrl_reg[CTRL_ACC_BIT];
            parallel_programmable_port_tx <= (ctrl_reg[CTRL_ACC_BIT] && !ctrl_reg[CTRL_ROUTE_BIT])
                                             ? tx_line_reg : 1'b1;
            gpio48_out <= tx_line_reg;
            gpio48_oe  <= ctrl_reg[CTRL_ACC_BIT] && ctrl_reg[CTRL_ROUTE_BIT];
        end
    end
endmodule // ucp_uart

// ===== ucp_uart_chk.sv
`timescale 1ns/1ps
module ucp_uart_chk
    import ucp_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Serial and accessory pins
    input wire logic        txd,
    input wire logic        usb_xcvr_en,
    input wire logic        usb_dm_oe,
    input wire logic        gpio48_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    answer_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    read_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    id_value_a: assert property (pready && !pwrite && paddr == ID_ADDR |-> prdata == ID_VALUE)
        else $error("id value wrong");
    unmapped_err_a: assert property (pready && paddr > ID_ADDR |-> pslverr)
        else $error("unmapped not refused");
    // ****************************************************************
    // Serial line and accessory routing
    // ****************************************************************
    acc_tx_idle_a: assert property (!usb_xcvr_en |-> txd)
        else $error("txd active in accessory");
    acc_dm_oe_a: assert property (usb_dm_oe == !usb_xcvr_en)
        else $error("d minus enable wrong");
    gpio_route_a: assert property (gpio48_oe |-> !usb_xcvr_en)
        else $error("gpio drive outside accessory");
    start_len_a: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit short");
    cover property (!usb_xcvr_en);
    cover property (gpio48_oe);
    cover property ($fell(txd));
endmodule // ucp_uart_chk

bind ucp_uart ucp_uart_chk chk (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .txd(txd), .usb_xcvr_en(usb_xcvr_en), .usb_dm_oe(usb_dm_oe), .gpio48_oe(gpio48_oe));

// ===== ucp_host_model.sv
`timescale 1ns/1ps
module ucp_host_model #(
    parameter int DIV = 21
) (
    // Clock
    input  wire logic clk,
    // Serial pins
    input  wire logic line_in,
    input  wire logic rts_in,
    input  wire logic stall,
    output logic      line_out,
    output logic      cts_out
);
    logic [7:0] rx_q[$];
    logic [7:0] shift;
    // Clear-to-send only while we can take data
    assign cts_out = !stall;
    initial line_out = 1'b1;
    // ****************************************************************
    // Receiver: mid-bit sampling, bad stop bit drops the character
    // ****************************************************************
    initial forever begin
        @(negedge line_in);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            shift[i] = line_in;
        end
        repeat (DIV) @(posedge clk);
        if (line_in === 1'b1) begin
            rx_q.push_back(shift);
        end
    end
    // ****************************************************************
    // Transmitter
    // ****************************************************************
    task automatic send(input logic [7:0] b);
        int k;
        k = 0;
        while (rts_in !== 1'b1 && k < 10000) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        line_out <= 1'b0;
        repeat (DIV) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            line_out <= b[i];
            repeat (DIV) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (DIV) @(posedge clk);
    endtask
endmodule // ucp_host_model

// ===== ucp_uart_tb.sv
`timescale 1ns/1ps
module ucp_uart_tb;
    import ucp_pkg::*;
    localparam int DIV = 21;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd_val;
    logic        pready;
    logic        pslverr;
    logic        err_bit;
    logic        txd;
    logic        rxd;
    logic        cts;
    logic        rts;
    logic        stall;
    logic        usb_xcvr_en;
    logic        usb_dm_out;
    logic        usb_dm_oe;
    logic        ppp_tx;
    logic        gpio48_out;
    logic        gpio48_oe;
    int          err_total;
    int          n_checks;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ucp_uart DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .txd(txd), .rxd(rxd), .cts(cts), .rts(rts), .usb_xcvr_en(usb_xcvr_en),
        .usb_dm_out(usb_dm_out), .usb_dm_oe(usb_dm_oe), .usb_dp_in(rxd),
        .parallel_programmable_port_tx(ppp_tx), .parallel_programmable_port_rx(1'b1),
        .gpio48_out(gpio48_out), .gpio48_oe(gpio48_oe), .gpio49_in(rxd));
    ucp_host_model #(.DIV(DIV)) host (.clk(clk), .line_in(txd), .rts_in(rts), .stall(stall),
        .line_out(rxd), .cts_out(cts));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_val = prdata;
        err_bit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            final_report;
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_val, exp);
    endtask
    // Waits for the host model to collect n characters
    task wait_rx(input int n);
        int k;
        k = 0;
        while (host.rx_q.size() < n && k < 5000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 5000) begin
            err_total++;
            final_report;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, reset_n} = '0;
        stall = 1'b1;
        err_total = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        chk({rts, txd}, 32'h1);
        reset_n <= 1'b1;
        rd(CTRL_ADDR, 32'h18);
        rd(BAUD_ADDR, 32'(DIV_RESET));
        rd(ID_ADDR, ID_VALUE);
        rd(STATUS_ADDR, 32'h8);
        rd(12'h018, 32'h0);
        chk(err_bit, 1'b1);
        apb(1'b1, BAUD_ADDR, 32'(DIV));
        rd(BAUD_ADDR, 32'(DIV));
        // A refused divisor reads back as written but only raises the error flag
        apb(1'b1, BAUD_ADDR, 32'(DIV - 1));
        rd(BAUD_ADDR, 32'(DIV - 1));
        rd(STATUS_ADDR, 32'h48);
        apb(1'b1, BAUD_ADDR, 32'(DIV));
        // Far side stalls while the buffer fills; the ninth byte must drop
        apb(1'b1, CTRL_ADDR, 32'h19);
        for (int i = 0; i < 9; i++) apb(1'b1, TXDATA_ADDR, 32'(i * 17 + 3));
        rd(STATUS_ADDR, 32'h5);
        repeat (100) @(posedge clk);
        chk(txd, 1'b1);
        stall <= 1'b0;
        wait_rx(8);
        for (int i = 0; i < 8; i++) chk(host.rx_q.pop_front(), 32'(i * 17 + 3));
        repeat (300) @(posedge clk);
        chk(32'(host.rx_q.size()), 32'h0);
        fork
            host.send(8'ha5);
            apb(1'b1, TXDATA_ADDR, 32'h5a);
        join
        wait_rx(1);
        chk(host.rx_q.pop_front(), 32'h5a);
        chk(rts, 1'b0);
        rd(RXDATA_ADDR, 32'h1a5);
        repeat (2) @(posedge clk);
        chk(rts, 1'b1);
        // Flow off: a second character while one is held overruns
        apb(1'b1, CTRL_ADDR, 32'h18);
        host.send(8'h3c);
        host.send(8'hc3);
        repeat (DIV) @(posedge clk);
        rd(STATUS_ADDR, 32'h2a);
        rd(RXDATA_ADDR, 32'h13c);
        rd(STATUS_ADDR, 32'h8);
        apb(1'b1, BAUD_ADDR, 32'd10417);
        apb(1'b1, CTRL_ADDR, 32'h1a);
        repeat (3) @(posedge clk);
        chk({usb_xcvr_en, usb_dm_oe, usb_dm_out, gpio48_oe, txd, ppp_tx}, 32'h1b);
        apb(1'b1, CTRL_ADDR, 32'h1e);
        repeat (3) @(posedge clk);
        chk({usb_xcvr_en, gpio48_oe, gpio48_out}, 32'h3);
        // Too fast for accessory mode: refused, old rate kept
        apb(1'b1, BAUD_ADDR, 32'(DIV));
        rd(BAUD_ADDR, 32'(DIV));
        rd(STATUS_ADDR, 32'h48);
        // Start bit appears on D- and the GPIO pin, never on txd
        apb(1'b1, TXDATA_ADDR, 32'h55);
        repeat (5) @(posedge clk);
        chk({txd, usb_dm_out, gpio48_out, ppp_tx}, 32'h9);
        final_report;
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        final_report;
    end
endmodule // ucp_uart_tb
